// *** core/asb_data_sync.sv ***
/*
 * Two-flop synchroniser for the memory data pins.
 * Assumes the pins settle long before the controller samples them.
 */
`timescale 1ns/1ps
module asb_data_sync (
    input  wire logic                       i_clk_sys,
    input  wire logic [asb_pkg::DATA_W-1:0] i_data,
    asb_rd_if.src                           rd
);
    logic [asb_pkg::DATA_W-1:0] meta;
    logic [asb_pkg::DATA_W-1:0] stable;

    // the first stage feeds only the second; nothing else looks at it
    always_ff @(posedge i_clk_sys) begin
        meta   <= i_data;
        stable <= meta;
    end

    assign rd.data = stable;
endmodule : asb_data_sync

// *** core/asb_host.sv ***
/*
 * Host-side controller for an asynchronous static memory of 2M x 16 or
 * 4M x 8: turns single read and write requests into pin sequences.
 * Assumes the memory is the only driver of the data pins besides this
 * block, and that the width strap input is static while out of reset.
 */
// Rules of the memory this block drives
// [RULE1] the address space is 2M 16-bit words on 21 lines, or 4M bytes in byte mode.
// [RULE2] a write is made by chip selects active and the write strobe driven low.
// [RULE3] a write with the lower lane selected stores data bits 0 to 7.
// [RULE4] a write with the upper lane selected stores bits 8 to 15; an unselected lane is kept.
// [RULE5] a read holds both chip selects active, output drive low and write strobe high.
// [RULE6] a read with the lower lane selected returns the lower byte on bits 0 to 7.
// [RULE7] a read with the upper lane selected returns the upper byte on bits 8 to 15.
// [RULE8] the memory floats its data pins when deselected, disabled, unlaned or writing.
// [RULE9] with a chip select inactive or both lanes off the memory is in standby.
// [RULE10] the width strap is high for word mode and low for byte mode and never changes.
// [RULE11] in byte mode the extra address bit is used and data moves on the lower lane only.
// [RULE12] the memory is level-sensitive; a write commits when the strobe is released.
`timescale 1ns/1ps
module asb_host #(
    parameter int ACCESS_CYC = asb_pkg::ACCESS_CYC,
    parameter int WRITE_CYC  = asb_pkg::WRITE_CYC
) (
    input  wire logic                            i_clk_sys,
    input  wire logic                            i_reset,
    input  wire logic                            i_word_mode,
    input  wire logic                            i_req_valid,
    input  wire logic                            i_req_write,
    input  wire logic [asb_pkg::REQ_ADDR_W-1:0]  i_req_addr,
    input  wire logic [asb_pkg::DATA_W-1:0]      i_req_wdata,
    input  wire logic [asb_pkg::LANES-1:0]       i_req_lanes,
    output logic                                 o_req_ready,
    output logic                                 o_rsp_valid,
    output logic [asb_pkg::DATA_W-1:0]           o_rsp_rdata,
    output logic [asb_pkg::WORD_ADDR_W-1:0]      o_addr,
    output logic                                 o_extra_lane_address_bit,
    output logic                                 o_chip_select_low_active_n,
    output logic                                 o_chip_select_high_active,
    output logic                                 o_write_strobe_n,
    output logic                                 o_output_drive_enable_n,
    output logic                                 o_lower_byte_lane_sel_n,
    output logic                                 o_upper_byte_lane_sel_n,
    output logic                                 o_width_select_pin,
    input  wire logic [asb_pkg::DATA_W-1:0]      i_data,
    output logic [asb_pkg::DATA_W-1:0]           o_data,
    output logic                                 o_data_oe
);

    localparam logic [asb_pkg::CNT_W-1:0] RD_LOAD =
        asb_pkg::CNT_W'(ACCESS_CYC + asb_pkg::SYNC_CYC - 1);
    localparam logic [asb_pkg::CNT_W-1:0] WR_LOAD = asb_pkg::CNT_W'(WRITE_CYC - 1);

    // ----------------------------------------------------------------------
    // read data input stage
    // ----------------------------------------------------------------------
    asb_rd_if rd ();

    asb_data_sync u_sync (
        .i_clk_sys (i_clk_sys),
        .i_data    (i_data),
        .rd        (rd)
    );

    function automatic logic [asb_pkg::DATA_W-1:0] merge_lanes(
        input logic [asb_pkg::DATA_W-1:0] bus,
        input logic [asb_pkg::LANES-1:0]  lanes,
        input logic                       word
    );
        logic [asb_pkg::DATA_W-1:0] r;
        r = asb_pkg::DATA_RST;
        if (!word) begin
            r[asb_pkg::BYTE_W-1:0] = bus[asb_pkg::BYTE_W-1:0];                      // RULE11
        end else begin
            if (lanes[0]) r[asb_pkg::BYTE_W-1:0] = bus[asb_pkg::BYTE_W-1:0];           // RULE6
            if (lanes[1]) r[asb_pkg::DATA_W-1:asb_pkg::BYTE_W] =
                bus[asb_pkg::DATA_W-1:asb_pkg::BYTE_W];                                // RULE7
        end
        return r;
    endfunction : merge_lanes

    // ----------------------------------------------------------------------
    // width strap, caught while reset is held
    // ----------------------------------------------------------------------
    logic word_mode;
    logic next_word_mode;
    logic strap_meta;
    logic strap_sync;

    always_comb begin
        next_word_mode = i_reset ? strap_sync : word_mode;                             // RULE10
    end

    // the strap comes from a board pin, so it passes two flops like any pin
    always_ff @(posedge i_clk_sys) begin
        strap_meta <= i_word_mode;
        strap_sync <= strap_meta;
        word_mode  <= next_word_mode;
    end

    // ----------------------------------------------------------------------
    // access sequencer
    // ----------------------------------------------------------------------
    asb_pkg::asb_state_e               state, next_state;
    logic [asb_pkg::CNT_W-1:0]         cnt, next_cnt;
    logic                              is_write, next_is_write;
    logic [asb_pkg::LANES-1:0]         lanes, next_lanes;
    logic                              next_req_ready, next_rsp_valid;
    logic [asb_pkg::DATA_W-1:0]        next_rsp_rdata;
    logic [asb_pkg::WORD_ADDR_W-1:0]   next_addr;
    logic                              next_extra;
    logic                              next_cs_n, next_cs_hi, next_we_n, next_oe_n;
    logic                              next_lo_n, next_hi_n;
    logic [asb_pkg::DATA_W-1:0]        next_data;
    logic                              next_data_oe;

    always_comb begin
        next_state     = state;
        next_cnt       = cnt;
        next_is_write  = is_write;
        next_lanes     = lanes;
        next_rsp_valid = 1'b0;
        next_rsp_rdata = o_rsp_rdata;
        next_addr      = o_addr;
        next_extra     = o_extra_lane_address_bit;
        next_cs_n      = o_chip_select_low_active_n;
        next_cs_hi     = o_chip_select_high_active;
        next_we_n      = 1'b1;
        next_oe_n      = 1'b1;
        next_lo_n      = o_lower_byte_lane_sel_n;
        next_hi_n      = o_upper_byte_lane_sel_n;
        next_data      = o_data;
        next_data_oe   = 1'b0;
        case (state)
            asb_pkg::ST_IDLE: begin
                next_cs_n  = 1'b1;
                next_cs_hi = 1'b0;
                if (i_req_valid && o_req_ready) begin
                    next_is_write = i_req_write;
                    next_lanes    = word_mode ? i_req_lanes : 2'h3;
                    next_addr     = i_req_addr[asb_pkg::WORD_ADDR_W-1:0];              // RULE1
                    next_extra    = word_mode ? 1'b0 :
                        i_req_addr[asb_pkg::REQ_ADDR_W-1];                             // RULE11
                    next_data     = word_mode ? i_req_wdata :
                        {8'h00, i_req_wdata[asb_pkg::BYTE_W-1:0]};                     // RULE11
                    if (word_mode && i_req_lanes == 2'h0) begin
                        // no lane wanted: the memory would sit in standby anyway
                        next_rsp_valid = 1'b1;                                         // RULE9
                        next_rsp_rdata = asb_pkg::DATA_RST;
                    end else begin
                        next_cs_n  = 1'b0;                                             // RULE2
                        next_cs_hi = 1'b1;                                             // RULE5
                        next_lo_n  = ~(word_mode ? i_req_lanes[0] : 1'b1);             // RULE3
                        next_hi_n  = ~(word_mode ? i_req_lanes[1] : 1'b1);             // RULE4
                        next_state = asb_pkg::ST_SETUP;
                    end
                end
            end
            asb_pkg::ST_SETUP: begin
                // address and selects settle one cycle before any strobe
                next_data_oe = is_write;
                next_we_n    = ~is_write;                                              // RULE2
                next_oe_n    = is_write;                                               // RULE5
                next_cnt     = is_write ? WR_LOAD : RD_LOAD;
                next_state   = asb_pkg::ST_STROBE;
            end
            asb_pkg::ST_STROBE: begin
                // host never drives the pins while the memory may drive them
                next_data_oe = is_write;                                               // RULE8
                if (cnt == '0) begin
                    if (!is_write) begin
                        next_rsp_rdata = merge_lanes(rd.data, lanes, word_mode);
                    end
                    next_state = asb_pkg::ST_HOLD;
                end else begin
                    next_cnt  = cnt - 1'b1;
                    next_we_n = ~is_write;
                    next_oe_n = is_write;
                end
            end
            asb_pkg::ST_HOLD: begin
                // data held past the strobe release, where the write commits
                next_data_oe   = 1'b0;                                                 // RULE12
                next_cs_n      = 1'b1;
                next_cs_hi     = 1'b0;
                next_rsp_valid = 1'b1;
                next_state     = asb_pkg::ST_IDLE;
            end
            default: begin
                next_state = asb_pkg::ST_IDLE;
            end
        endcase
        next_req_ready = (next_state == asb_pkg::ST_IDLE) && !next_rsp_valid;
        if (i_reset) begin
            next_state     = asb_pkg::ST_IDLE;
            next_cnt       = '0;
            next_is_write  = 1'b0;
            next_lanes     = 2'h0;
            next_req_ready = 1'b0;
            next_rsp_valid = 1'b0;
            next_rsp_rdata = asb_pkg::DATA_RST;
            next_addr      = asb_pkg::ADDR_RST;
            next_extra     = 1'b0;
            next_cs_n      = 1'b1;
            next_cs_hi     = 1'b0;
            next_we_n      = 1'b1;
            next_oe_n      = 1'b1;
            next_lo_n      = 1'b1;
            next_hi_n      = 1'b1;
            next_data      = asb_pkg::DATA_RST;
            next_data_oe   = 1'b0;
        end
    end

    always_ff @(posedge i_clk_sys) begin
        state                      <= next_state;
        cnt                        <= next_cnt;
        is_write                   <= next_is_write;
        lanes                      <= next_lanes;
        o_req_ready                <= next_req_ready;
        o_rsp_valid                <= next_rsp_valid;
        o_rsp_rdata                <= next_rsp_rdata;
        o_addr                     <= next_addr;
        o_extra_lane_address_bit   <= next_extra;
        o_chip_select_low_active_n <= next_cs_n;
        o_chip_select_high_active  <= next_cs_hi;
        o_write_strobe_n           <= next_we_n;
        o_output_drive_enable_n    <= next_oe_n;
        o_lower_byte_lane_sel_n    <= next_lo_n;
        o_upper_byte_lane_sel_n    <= next_hi_n;
        o_data                     <= next_data;
        o_data_oe                  <= next_data_oe;
        o_width_select_pin         <= next_word_mode;
    end

endmodule : asb_host

// *** core/asb_pkg.sv ***
/*
 * Constants shared by the static memory host controller and its helpers.
 * Assumes a 125 MHz system clock and one asynchronous memory on the pins.
 */
package asb_pkg;

    // --------------------------------------------------------------------
    // organisation
    // --------------------------------------------------------------------
    localparam int WORD_ADDR_W = 21;
    localparam int REQ_ADDR_W  = 22;
    localparam int DATA_W      = 16;
    localparam int BYTE_W      = 8;
    localparam int LANES       = 2;

    // --------------------------------------------------------------------
    // timing
    // --------------------------------------------------------------------
    localparam int CLK_PERIOD_NS     = 8;
    localparam int T_ACCESS_NS       = 70;
    localparam int T_WRITE_PULSE_NS  = 70;
    localparam int ACCESS_CYC        = (T_ACCESS_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int WRITE_CYC         = (T_WRITE_PULSE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int SYNC_CYC          = 2;
    localparam int CNT_W             = 5;

    // --------------------------------------------------------------------
    // reset values
    // --------------------------------------------------------------------
    localparam logic [DATA_W-1:0]      DATA_RST = 16'h0000;
    localparam logic [WORD_ADDR_W-1:0] ADDR_RST = 21'h000000;

    typedef enum logic [1:0] {
        ST_IDLE,
        ST_SETUP,
        ST_STROBE,
        ST_HOLD
    } asb_state_e;

endpackage : asb_pkg

// *** core/asb_rd_if.sv ***
/*
 * Carries the synchronised read-data bus from the input stage to the
 * controller. Assumes both ends run on i_clk_sys.
 */
`timescale 1ns/1ps
interface asb_rd_if;
    logic [asb_pkg::DATA_W-1:0] data;
    modport src (output data);
    modport dst (input  data);
endinterface : asb_rd_if

// *** test/asb_host_monitor.sv ***
/* Pin and latency checker for the static memory host.
   Assumes it is bound to asb_host and sees only its ports. */
`timescale 1ns/1ps
module asb_host_monitor #(
    parameter int ACCESS_CYC = 1,
    parameter int WRITE_CYC  = 1
) (
    input wire logic        i_clk_sys,
    input wire logic        i_reset,
    input wire logic        i_req_valid,
    input wire logic        i_req_write,
    input wire logic [1:0]  i_req_lanes,
    input wire logic        o_req_ready,
    input wire logic        o_rsp_valid,
    input wire logic [20:0] o_addr,
    input wire logic        o_extra_lane_address_bit,
    input wire logic        o_chip_select_low_active_n,
    input wire logic        o_chip_select_high_active,
    input wire logic        o_write_strobe_n,
    input wire logic        o_output_drive_enable_n,
    input wire logic        o_lower_byte_lane_sel_n,
    input wire logic        o_upper_byte_lane_sel_n,
    input wire logic        o_width_select_pin,
    input wire logic [15:0] o_data,
    input wire logic        o_data_oe
);
    // the answer is registered at take + strobe + 2 and seen one sample later
    localparam int WL = WRITE_CYC + 3;
    localparam int RL = ACCESS_CYC + asb_pkg::SYNC_CYC + 3;
    logic go;
    // a word-mode request with no lanes finishes at once, so it is left out
    assign go = i_req_valid && o_req_ready && (i_req_lanes != 2'b00 || !o_width_select_pin);
    default clocking cb @(posedge i_clk_sys); endclocking
    default disable iff (i_reset);
    chk_write_lat: assert property (go && i_req_write |-> ##WL o_rsp_valid)
        else $error("write answer late or missing");
    chk_read_lat: assert property (go && !i_req_write |-> ##RL o_rsp_valid)
        else $error("read answer late or missing");
    chk_write_pins: assert property (!o_write_strobe_n |-> !o_chip_select_low_active_n
        && o_chip_select_high_active && o_output_drive_enable_n && o_data_oe)
        else $error("write strobe without selects or data");
    chk_read_pins: assert property (!o_output_drive_enable_n |-> o_write_strobe_n
        && !o_chip_select_low_active_n && o_chip_select_high_active && !o_data_oe)
        else $error("read without selects or with host driving");
    chk_commit_hold: assert property ($rose(o_write_strobe_n) |-> o_data_oe
        && $stable(o_data) && $stable(o_addr) ##1 o_chip_select_low_active_n)
        else $error("data or address not held past strobe release");
    chk_byte_lanes: assert property (!o_width_select_pin && !o_chip_select_low_active_n
        |-> !o_lower_byte_lane_sel_n && !o_upper_byte_lane_sel_n)
        else $error("byte mode access without both lane selects");
    chk_word_extra: assert property (o_width_select_pin |-> !o_extra_lane_address_bit)
        else $error("extra address bit set in word mode");
    chk_strap_hold: assert property ($stable(o_width_select_pin))
        else $error("width strap changed out of reset");
    chk_no_standby: assert property (o_width_select_pin && !o_chip_select_low_active_n
        |-> !(o_lower_byte_lane_sel_n && o_upper_byte_lane_sel_n))
        else $error("selected with no lane enabled");
endmodule : asb_host_monitor
bind asb_host asb_host_monitor #(.ACCESS_CYC(ACCESS_CYC), .WRITE_CYC(WRITE_CYC)) u_mon (.*);

// *** test/asb_host_tb_top.sv ***
/* Self-checking bench: host controller against the memory model.
   Assumes short access and write counts of one cycle each. */
`timescale 1ns/1ps
module asb_host_tb_top;
    logic        i_clk_sys, i_reset, i_word_mode, i_req_valid, i_req_write;
    logic [21:0] i_req_addr;
    logic [15:0] i_req_wdata, o_data, o_rsp_rdata, q, bus, last_bus;
    logic [1:0]  i_req_lanes, en;
    logic [20:0] o_addr;
    logic [31:0] r, r2;
    logic        rdy, rv, ex, cs_n, cs_hi, we_n, oe_n, lo_n, up_n, wsel, doe;
    logic [15:0] sh [int];
    int          seed, fail_count, n_tests;
    asb_host #(.ACCESS_CYC(1), .WRITE_CYC(1)) dut (
        .i_clk_sys(i_clk_sys), .i_reset(i_reset), .i_word_mode(i_word_mode),
        .i_req_valid(i_req_valid), .i_req_write(i_req_write), .i_req_addr(i_req_addr),
        .i_req_wdata(i_req_wdata), .i_req_lanes(i_req_lanes), .o_req_ready(rdy),
        .o_rsp_valid(rv), .o_rsp_rdata(o_rsp_rdata), .o_addr(o_addr),
        .o_extra_lane_address_bit(ex), .o_chip_select_low_active_n(cs_n),
        .o_chip_select_high_active(cs_hi), .o_write_strobe_n(we_n),
        .o_output_drive_enable_n(oe_n), .o_lower_byte_lane_sel_n(lo_n),
        .o_upper_byte_lane_sel_n(up_n), .o_width_select_pin(wsel), .i_data(bus),
        .o_data(o_data), .o_data_oe(doe));
    asb_sram_model u_mem (.i_addr(o_addr), .i_extra(ex), .i_cs_n(cs_n), .i_cs_hi(cs_hi),
        .i_we_n(we_n), .i_oe_n(oe_n), .i_lo_sel_n(lo_n), .i_up_sel_n(up_n), .i_wide(wsel),
        .i_bus(bus), .o_q(q), .o_en(en));
    // a released lane shows the inverse of its last level, never a lucky match
    assign bus[7:0]  = doe ? o_data[7:0]  : en[0] ? q[7:0]  : ~last_bus[7:0];
    assign bus[15:8] = doe ? o_data[15:8] : en[1] ? q[15:8] : ~last_bus[15:8];
    always @(posedge i_clk_sys) last_bus <= bus;
    initial begin
        i_clk_sys = 1'b0;
        forever #4 i_clk_sys = ~i_clk_sys;
    end
    function automatic logic [15:0] lane_mask(input logic [15:0] w, input logic [1:0] m);
        return {m[1] ? w[15:8] : 8'h00, m[0] ? w[7:0] : 8'h00};
    endfunction : lane_mask
    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        n_tests++;
        if (got !== exp) begin
            fail_count++;
            $display("[FAIL] %0t got %h expected %h", $time, got, exp);
        end
    endtask : chk
    task automatic summarize();
        if (fail_count == 0 && n_tests > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask : summarize
    task automatic wait_on(input int k);
        if (k >= 40) begin
            fail_count++;
            $display("[FAIL] %0t handshake timeout", $time);
            summarize();
        end
    endtask : wait_on
    task automatic do_reset(input logic mode);
        i_word_mode = mode;
        i_reset = 1'b1;
        repeat (8) @(negedge i_clk_sys);
        i_reset = 1'b0;
        chk({15'h0000, wsel}, {15'h0000, mode});
    endtask : do_reset
    task automatic xfer(input logic wr, input logic [21:0] a, input logic [15:0] d,
                        input logic [1:0] ln);
        int k;
        int key;
        logic [1:0] m;
        logic [15:0] w;
        key = {10'h000, a[21] & ~i_word_mode, a[20:0]};
        w = sh.exists(key) ? sh[key] : 16'h0000;
        m = i_word_mode ? ln : 2'b01;
        for (k = 0; k < 40 && rdy !== 1'b1; k++) @(negedge i_clk_sys);
        wait_on(k);
        i_req_valid = 1'b1;
        i_req_write = wr;
        i_req_addr = a;
        i_req_wdata = d;
        i_req_lanes = ln;
        @(negedge i_clk_sys);
        i_req_valid = 1'b0;
        for (k = 0; k < 40 && rv !== 1'b1; k++) @(negedge i_clk_sys);
        wait_on(k);
        if (wr) sh[key] = lane_mask(d, m) | lane_mask(w, ~m);
        else chk(o_rsp_rdata, lane_mask(w, m));
    endtask : xfer
    initial begin
        seed = 32'h83166CC6;
        fail_count = 0;
        n_tests = 0;
        last_bus = 16'h0000;
        {i_req_valid, i_req_write, i_req_addr, i_req_wdata, i_req_lanes} = '0;
        do_reset(1'b1);
        // top word: full write, partial overwrite through the aliased bit 21
        xfer(1'b1, 22'h1FFFFF, 16'hFFFF, 2'b11);
        xfer(1'b1, 22'h3FFFFF, 16'h1234, 2'b01);
        for (int m = 0; m < 4; m++) xfer(1'b0, 22'h1FFFFF, 16'h0000, 2'(m));
        for (int n = 0; n < 160; n++) begin
            if (n == 80) do_reset(1'b0);
            r = $random(seed);
            r2 = $random(seed);
            xfer(r[0], r[31:10] & 22'h300007, r2[15:0], r[2:1]);
        end
        summarize();
    end
endmodule : asb_host_tb_top

// *** test/asb_sram_model.sv ***
/* Behavioural static memory, 2M x 16 or 4M x 8, no clock.
   Assumes the bench resolves the shared data pins from both drivers. */
`timescale 1ns/1ps
module asb_sram_model (
    input  wire logic [20:0] i_addr,
    input  wire logic        i_extra,
    input  wire logic        i_cs_n,
    input  wire logic        i_cs_hi,
    input  wire logic        i_we_n,
    input  wire logic        i_oe_n,
    input  wire logic        i_lo_sel_n,
    input  wire logic        i_up_sel_n,
    input  wire logic        i_wide,
    input  wire logic [15:0] i_bus,
    output logic      [15:0] o_q,
    output logic      [1:0]  o_en
);
    logic [15:0] mem [int];
    logic [15:0] pd;
    logic [15:0] old;
    logic [1:0]  pl;
    logic        sel;
    logic        rd;
    logic        wr_on;
    logic        pv = 1'b0;
    int          key;
    int          pk;
    assign sel   = !i_cs_n && i_cs_hi && !(i_wide && i_lo_sel_n && i_up_sel_n);
    assign wr_on = sel && !i_we_n;
    assign rd    = sel && !i_oe_n && i_we_n;
    assign key   = {10'h000, i_extra & ~i_wide, i_addr};
    assign o_en  = {rd && i_wide && !i_up_sel_n, rd && (!i_wide || !i_lo_sel_n)};
    always @* begin
        o_q = (rd && mem.exists(key)) ? mem[key] : 16'h0000;
    end
    // capture while the strobe is low; the cell only changes when it ends
    always @* begin
        if (wr_on) begin
            pk = key;
            pd = i_bus;
            pl = {i_up_sel_n, i_lo_sel_n};
            pv = 1'b1;
        end
    end
    always @(negedge wr_on) begin
        if (pv) begin
            old = mem.exists(pk) ? mem[pk] : 16'h0000;
            if (!pl[0]) old[7:0] = pd[7:0];
            if (!pl[1]) old[15:8] = pd[15:8];
            if (!i_wide) old = {8'h00, pd[7:0]};
            mem[pk] = old;
            pv = 1'b0;
        end
    end
endmodule : asb_sram_model
